// >>> core/cop_policy_regs.v
// How it works
// [R1] rx icmp drop bit discards bad icmp
// [R2] clear drop bit: deliver, mark header error
// [R3] rx igmp drop bit discards bad igmp
// [R4] rx icmpv6 drop bit discards bad icmpv6
// [R5] tunnel bit enables l4 check in tunnels
// [R6] pppoe bit enables rx pppoe parsing
// [R7] ipv6 has own per-protocol drop bits
// [R8] tx control read 2dh, written 2eh
// [R9] tx bit 0 inserts ipv4 header checksum
// [R10] tx bits 1,2 insert tcp, udp
// [R11] tx bits 3-5 insert icmp, igmp, icmpv6
// [R12] second tx byte: ipv6 insertion enables
// [R13] tx tunnel bit inserts tunnelled l4 checksum
// [R14] tx pppoe bit inverted: one disables
// [R15] ipv4 header drop bit discards bad headers
// [R16] l4 drop only matters when checking enabled
// [R17] drop decided after full packet evaluated
// [R18] all policy bits zero after reset
`include "cop_defs.vh"

module cop_policy_regs (
  input  wire        CLOCK_IN,        // 50 mhz system clock
  input  wire        SYS_RST_IN,      // async reset, active high
  // vendor register command port
  input  wire        CMD_VALID_IN,    // command strobe
  input  wire        CMD_WRITE_IN,    // 1 write, 0 read
  input  wire [7:0]  CMD_INDEX_IN,    // vendor register index
  input  wire [31:0] CMD_WDATA_IN,    // write data {dd,cc,bb,aa}
  output wire        CMD_READY_OUT,   // command always taken
  output reg         RD_VALID_OUT,    // read data pulse
  output reg  [31:0] RD_DATA_OUT,     // read data
  // per-packet rx checksum result
  input  wire [4:0]  RX_CHECK_EN_IN,  // l4 check enables tcp..icmpv6
  input  wire        RX_DONE_IN,      // end-of-packet result pulse
  input  wire        RX_IPV6_IN,      // packet is ipv6
  input  wire        RX_TUNNEL_IN,    // ipv6 in ipv4 tunnel
  input  wire        RX_PPPOE_IN,     // pppoe encapsulated
  input  wire [2:0]  RX_PROTO_IN,     // l4 protocol code
  input  wire        RX_IPHDR_ERR_IN, // ipv4 header checksum bad
  input  wire        RX_L4_ERR_IN,    // l4 checksum bad
  output wire        RX_VERDICT_OUT,  // verdict pulse
  output wire        RX_DROP_OUT,     // discard packet
  output wire        RX_FLAG_OUT,     // mark error in rx header
  // settings to the rx parser
  output wire        RX_TUNNEL_L4_CHECK_OUT, // check tunnelled l4
  output wire        RX_PPPOE_PARSE_OUT,     // parse pppoe on rx
  // settings to the tx engine
  output wire        TX_IPV4_HDR_INSERT_OUT, // ipv4 header checksum
  output wire        TX_TCP_INSERT_OUT,      // ipv4 tcp
  output wire        TX_UDP_INSERT_OUT,      // ipv4 udp
  output wire        TX_ICMP_INSERT_OUT,     // ipv4 icmp
  output wire        TX_IGMP_INSERT_OUT,     // ipv4 igmp
  output wire        TX_ICMPV6_INSERT_OUT,   // ipv4 icmpv6
  output wire [4:0]  TX_V6_INSERT_OUT,       // ipv6 tcp,udp,icmp,igmp,icmpv6
  output wire        TX_TUNNEL_L4_INSERT_OUT, // tunnelled l4 insert
  output wire        TX_PPPOE_PARSE_OUT      // pppoe parsing enabled on tx
);

  // stored policy bytes
  reg  [7:0]  tx_aa_reg;          // tx ipv4 insertion enables
  reg  [7:0]  tx_bb_reg;          // tx ipv6 insertion enables
  reg  [7:0]  tx_cc_reg;          // tx tunnel and pppoe control
  reg  [7:0]  rx_cc_reg;          // rx ipv4 drop policy
  reg  [7:0]  rx_dd_reg;          // rx ipv6, tunnel and pppoe policy
  // next values from the command port
  reg  [7:0]  tx_aa_next;
  reg  [7:0]  tx_bb_next;
  reg  [7:0]  tx_cc_next;
  reg  [7:0]  rx_cc_next;
  reg  [7:0]  rx_dd_next;
  reg  [31:0] rd_data_next;

  // index match of a command; shared by every write and read decode
  function idx_is;
    input [7:0] idx;
    input [7:0] want;
    begin
      idx_is = (idx == want);
    end
  endfunction

  // writable bits of one byte lane; reserved bits are not stored, except rx byte cc bits 1 and 2 (mask ff)
  function [7:0] lane_keep;
    input [7:0] lane;
    input [7:0] mask;
    begin
      lane_keep = lane & mask;
    end
  endfunction

  // command decode
  wire wr_en  = CMD_VALID_IN && CMD_WRITE_IN;
  wire rd_en  = CMD_VALID_IN && !CMD_WRITE_IN;
  wire wr_txc = wr_en && idx_is(CMD_INDEX_IN, `COP_TXC_WR_IDX);   // [R8]
  wire wr_rxp = wr_en && idx_is(CMD_INDEX_IN, `COP_RXP_WR_IDX);

  // commands are never stalled
  assign CMD_READY_OUT = 1'b1;

  // next register values; only a write at a write index changes them
  always @* begin
    tx_aa_next = tx_aa_reg;
    tx_bb_next = tx_bb_reg;
    tx_cc_next = tx_cc_reg;
    rx_cc_next = rx_cc_reg;
    rx_dd_next = rx_dd_reg;
    if (wr_txc) begin
      tx_aa_next = lane_keep(CMD_WDATA_IN[`COP_LANE_AA], `COP_TXC_AA_MASK);
      tx_bb_next = lane_keep(CMD_WDATA_IN[`COP_LANE_BB], `COP_TXC_BB_MASK); // [R12]
      tx_cc_next = lane_keep(CMD_WDATA_IN[`COP_LANE_CC], `COP_TXC_CC_MASK);
    end
    if (wr_rxp) begin
      rx_cc_next = lane_keep(CMD_WDATA_IN[`COP_LANE_CC], `COP_RXP_CC_MASK);
      rx_dd_next = lane_keep(CMD_WDATA_IN[`COP_LANE_DD], `COP_RXP_DD_MASK);
    end
  end

  // tx ipv4 insertion byte
  always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      tx_aa_reg <= `COP_TXC_BYTE_RST;                           // [R18]
    end else begin
      tx_aa_reg <= tx_aa_next;
    end
  end

  // tx ipv6 insertion byte
  always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      tx_bb_reg <= `COP_TXC_BYTE_RST;                           // [R18]
    end else begin
      tx_bb_reg <= tx_bb_next;
    end
  end

  // tx tunnel and pppoe byte; zero leaves tx pppoe parsing on
  always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      tx_cc_reg <= `COP_TXC_BYTE_RST;                           // [R18]
    end else begin
      tx_cc_reg <= tx_cc_next;
    end
  end

  // rx ipv4 drop policy byte
  always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rx_cc_reg <= `COP_RXP_RST;                                // [R18]
    end else begin
      rx_cc_reg <= rx_cc_next;
    end
  end

  // rx ipv6 drop, tunnel and pppoe byte
  always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rx_dd_reg <= `COP_RXP_RST;                                // [R18]
    end else begin
      rx_dd_reg <= rx_dd_next;
    end
  end

  // read mux; write-only indexes and unmapped read as zero
  always @* begin
    rd_data_next = `COP_RD_DATA_RST;
    if (idx_is(CMD_INDEX_IN, `COP_TXC_RD_IDX)) begin            // [R8]
      rd_data_next[`COP_LANE_AA] = tx_aa_reg;
      rd_data_next[`COP_LANE_BB] = tx_bb_reg;
      rd_data_next[`COP_LANE_CC] = tx_cc_reg;
    end else if (idx_is(CMD_INDEX_IN, `COP_RXP_RD_IDX)) begin
      rd_data_next[`COP_LANE_CC] = rx_cc_reg;
      rd_data_next[`COP_LANE_DD] = rx_dd_reg;
    end
  end

  // read answer strobe, one cycle after the command
  always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RD_VALID_OUT <= 1'b0;
    end else begin
      RD_VALID_OUT <= rd_en;
    end
  end

  // read data, held until the next read
  always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RD_DATA_OUT <= `COP_RD_DATA_RST;
    end else begin
      if (rd_en) begin
        RD_DATA_OUT <= rd_data_next;
      end
    end
  end

  // rx parser settings
  assign RX_TUNNEL_L4_CHECK_OUT = rx_dd_reg[`COP_DD_TUNNEL];   // [R5]
  assign RX_PPPOE_PARSE_OUT     = rx_dd_reg[`COP_DD_PPPOE];    // [R6]

  // tx insertion enables and tx pppoe parse enable
  assign TX_IPV4_HDR_INSERT_OUT  = tx_aa_reg[`COP_AA_IP];      // [R9]
  assign TX_TCP_INSERT_OUT       = tx_aa_reg[`COP_AA_TCP];     // [R10]
  assign TX_UDP_INSERT_OUT       = tx_aa_reg[`COP_AA_UDP];     // [R10]
  assign TX_ICMP_INSERT_OUT      = tx_aa_reg[`COP_AA_ICMP];    // [R11]
  assign TX_IGMP_INSERT_OUT      = tx_aa_reg[`COP_AA_IGMP];    // [R11]
  assign TX_ICMPV6_INSERT_OUT    = tx_aa_reg[`COP_AA_ICMPV6];  // [R11]
  assign TX_V6_INSERT_OUT        = tx_bb_reg[`COP_BB_V6_FIELD]; // [R12]
  assign TX_TUNNEL_L4_INSERT_OUT = tx_cc_reg[`COP_CCT_TUNNEL]; // [R13]
  assign TX_PPPOE_PARSE_OUT      = !tx_cc_reg[`COP_CCT_PPPOE_N]; // [R14]

  // per-packet drop or flag decision
  cop_rx_verdict u_verdict (
    .clk       (CLOCK_IN),
    .rst       (SYS_RST_IN),
    .drop_v4   (rx_cc_reg),
    .drop_v6   (rx_dd_reg),
    .check_en  (RX_CHECK_EN_IN),
    .done      (RX_DONE_IN),
    .is_ipv6   (RX_IPV6_IN),
    .is_tunnel (RX_TUNNEL_IN),
    .is_pppoe  (RX_PPPOE_IN),
    .proto     (RX_PROTO_IN),
    .iphdr_err (RX_IPHDR_ERR_IN),
    .l4_err    (RX_L4_ERR_IN),
    .valid_out (RX_VERDICT_OUT),
    .drop_out  (RX_DROP_OUT),
    .flag_out  (RX_FLAG_OUT)
  );

endmodule // cop_policy_regs

// >>> core/cop_defs.vh
`ifndef COP_DEFS_VH
`define COP_DEFS_VH

// vendor register indexes of the tx insertion control register
`define COP_TXC_RD_IDX      8'h2d
`define COP_TXC_WR_IDX      8'h2e
// vendor register indexes of the rx drop policy register
`define COP_RXP_RD_IDX      8'h2b
`define COP_RXP_WR_IDX      8'h2c

// reset values
`define COP_TXC_RST         32'h00000000
`define COP_RXP_RST         8'h00
`define COP_TXC_BYTE_RST    8'h00
`define COP_RD_DATA_RST     32'h00000000

// byte lanes within a 32-bit vendor register word
`define COP_LANE_AA         7:0
`define COP_LANE_BB         15:8
`define COP_LANE_CC         23:16
`define COP_LANE_DD         31:24

// writable field masks
`define COP_TXC_AA_MASK     8'h3f
`define COP_TXC_BB_MASK     8'h1f
`define COP_TXC_CC_MASK     8'h03
`define COP_RXP_DD_MASK     8'h7f
`define COP_RXP_CC_MASK     8'hff

// rx policy byte CC fields
`define COP_CC_IPHDR_DP     0
`define COP_CC_TCP_DP       3
`define COP_CC_UDP_DP       4
`define COP_CC_ICMP_DP      5
`define COP_CC_IGMP_DP      6
`define COP_CC_ICMPV6_DP    7
// rx policy byte DD fields
`define COP_DD_TUNNEL       0
`define COP_DD_PPPOE        1
`define COP_DD_TCP6_DP      2
`define COP_DD_UDP6_DP      3
`define COP_DD_ICMP6_DP     4
`define COP_DD_IGMP6_DP     5
`define COP_DD_ICMPV66_DP   6

// tx byte AA fields
`define COP_AA_IP           0
`define COP_AA_TCP          1
`define COP_AA_UDP          2
`define COP_AA_ICMP         3
`define COP_AA_IGMP         4
`define COP_AA_ICMPV6       5
// tx byte BB fields
`define COP_BB_TCP6         0
`define COP_BB_UDP6         1
`define COP_BB_ICMP6        2
`define COP_BB_IGMP6        3
`define COP_BB_ICMPV66      4
`define COP_BB_V6_FIELD     4:0
// tx byte CC fields
`define COP_CCT_TUNNEL      0
`define COP_CCT_PPPOE_N     1

// layer-4 protocol codes of a checked packet
`define COP_PROTO_TCP       3'h0
`define COP_PROTO_UDP       3'h1
`define COP_PROTO_ICMP      3'h2
`define COP_PROTO_IGMP      3'h3
`define COP_PROTO_ICMPV6    3'h4

`endif

// >>> core/cop_rx_verdict.v
`include "cop_defs.vh"

// per-packet drop or flag decision, taken once the checksum result is final
module cop_rx_verdict (
  input  wire       clk,              // system clock
  input  wire       rst,              // async reset, active high
  input  wire [7:0] drop_v4,          // policy byte cc
  input  wire [7:0] drop_v6,          // policy byte dd
  input  wire [4:0] check_en,         // rx l4 check enables per protocol
  input  wire       done,             // end-of-packet result pulse
  input  wire       is_ipv6,          // packet is ipv6
  input  wire       is_tunnel,        // ipv6 carried in ipv4
  input  wire       is_pppoe,         // pppoe encapsulated
  input  wire [2:0] proto,            // l4 protocol code
  input  wire       iphdr_err,        // ipv4 header checksum failed
  input  wire       l4_err,           // l4 checksum failed
  output reg        valid_out,        // verdict pulse
  output reg        drop_out,         // discard whole packet
  output reg        flag_out          // deliver with error mark
);

  // drop policy bit for a protocol and ip version
  function drop_sel;
    input [2:0] p;
    input       v6;
    input [7:0] cc;
    input [7:0] dd;
    begin
      case (p)
        `COP_PROTO_TCP:    drop_sel = v6 ? dd[`COP_DD_TCP6_DP]    : cc[`COP_CC_TCP_DP];
        `COP_PROTO_UDP:    drop_sel = v6 ? dd[`COP_DD_UDP6_DP]    : cc[`COP_CC_UDP_DP];
        `COP_PROTO_ICMP:   drop_sel = v6 ? dd[`COP_DD_ICMP6_DP]   : cc[`COP_CC_ICMP_DP];
        `COP_PROTO_IGMP:   drop_sel = v6 ? dd[`COP_DD_IGMP6_DP]   : cc[`COP_CC_IGMP_DP];
        `COP_PROTO_ICMPV6: drop_sel = v6 ? dd[`COP_DD_ICMPV66_DP] : cc[`COP_CC_ICMPV6_DP];
        default:           drop_sel = 1'b0;
      endcase
    end
  endfunction

  wire proto_ok  = (proto <= `COP_PROTO_ICMPV6);
  // l4 result counts only if enabled and the frame was parsed
  wire l4_live   = proto_ok && check_en[proto] &&                           // [R16]
                   (!is_tunnel || drop_v6[`COP_DD_TUNNEL]) &&               // [R5]
                   (!is_pppoe || drop_v6[`COP_DD_PPPOE]);                   // [R6]
  wire l4_fail   = l4_err && l4_live;
  wire hdr_fail  = iphdr_err && !is_ipv6;
  wire drop_now  = (hdr_fail && drop_v4[`COP_CC_IPHDR_DP]) ||               // [R15]
                   (l4_fail && drop_sel(proto, is_ipv6, drop_v4, drop_v6)); // [R1] [R3] [R4] [R7]

  // verdict only on the end-of-packet pulse, never mid-packet
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_out <= 1'b0;
      drop_out  <= 1'b0;
      flag_out  <= 1'b0;
    end else begin
      valid_out <= done;                                                    // [R17]
      drop_out  <= done && drop_now;
      flag_out  <= done && (hdr_fail || l4_fail) && !drop_now;              // [R2]
    end
  end

endmodule // cop_rx_verdict

// >>> verification/cop_policy_regs_properties.sv
module cop_policy_regs_properties (
  input logic        CLOCK_IN,
  input logic        SYS_RST_IN,
  input logic        CMD_VALID_IN,
  input logic        CMD_WRITE_IN,
  input logic [7:0]  CMD_INDEX_IN,
  input logic        RD_VALID_OUT,
  input logic [31:0] RD_DATA_OUT,
  input logic [4:0]  RX_CHECK_EN_IN,
  input logic        RX_DONE_IN,
  input logic        RX_IPV6_IN,
  input logic [2:0]  RX_PROTO_IN,
  input logic        RX_IPHDR_ERR_IN,
  input logic        RX_L4_ERR_IN,
  input logic        RX_VERDICT_OUT,
  input logic        RX_DROP_OUT,
  input logic        RX_FLAG_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // command and packet events
  sequence s_read_cmd;
    CMD_VALID_IN && !CMD_WRITE_IN;
  endsequence
  sequence s_hdr_bad;
    RX_DONE_IN && RX_IPHDR_ERR_IN && !RX_IPV6_IN;
  endsequence
  a_read_answer_next: assert property (s_read_cmd |=> RD_VALID_OUT)
    else $error("read answer missing");
  a_rdvalid_needs_read: assert property (RD_VALID_OUT |-> $past(CMD_VALID_IN && !CMD_WRITE_IN))
    else $error("read answer without read");
  a_unmapped_read_zero: assert property (s_read_cmd ##0 (CMD_INDEX_IN != 8'h2b
    && CMD_INDEX_IN != 8'h2d) |=> RD_DATA_OUT == 32'h00000000)
    else $error("unmapped read not zero");
  a_verdict_after_done: assert property (RX_DONE_IN |=> RX_VERDICT_OUT)
    else $error("verdict missing");
  a_no_early_verdict: assert property (!RX_DONE_IN |=> !(RX_VERDICT_OUT || RX_DROP_OUT
    || RX_FLAG_OUT))
    else $error("verdict without packet end");
  a_drop_flag_excl: assert property (!(RX_DROP_OUT && RX_FLAG_OUT))
    else $error("drop and flag together");
  a_outcome_needs_err: assert property ((RX_DROP_OUT || RX_FLAG_OUT)
    |-> $past(RX_L4_ERR_IN || RX_IPHDR_ERR_IN && !RX_IPV6_IN))
    else $error("outcome without error");
  a_hdr_err_outcome: assert property (s_hdr_bad |=> RX_DROP_OUT || RX_FLAG_OUT)
    else $error("header error ignored");
  a_disabled_no_l4: assert property (RX_DONE_IN && !RX_IPHDR_ERR_IN && RX_PROTO_IN < 3'h5
    && !RX_CHECK_EN_IN[RX_PROTO_IN] |=> !RX_DROP_OUT && !RX_FLAG_OUT)
    else $error("disabled check acted");
endmodule // cop_policy_regs_properties

bind cop_policy_regs cop_policy_regs_properties cop_policy_regs_properties_inst (
  .CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN), .CMD_VALID_IN(CMD_VALID_IN),
  .CMD_WRITE_IN(CMD_WRITE_IN), .CMD_INDEX_IN(CMD_INDEX_IN), .RD_VALID_OUT(RD_VALID_OUT),
  .RD_DATA_OUT(RD_DATA_OUT), .RX_CHECK_EN_IN(RX_CHECK_EN_IN), .RX_DONE_IN(RX_DONE_IN),
  .RX_IPV6_IN(RX_IPV6_IN), .RX_PROTO_IN(RX_PROTO_IN), .RX_IPHDR_ERR_IN(RX_IPHDR_ERR_IN),
  .RX_L4_ERR_IN(RX_L4_ERR_IN), .RX_VERDICT_OUT(RX_VERDICT_OUT),
  .RX_DROP_OUT(RX_DROP_OUT), .RX_FLAG_OUT(RX_FLAG_OUT));

// >>> verification/cop_host_model.sv
module cop_host_model (
  input  logic        clk_in,      // system clock
  output logic        valid_out,   // command strobe
  output logic        write_out,   // 1 write, 0 read
  output logic [7:0]  index_out,   // vendor register index
  output logic [31:0] wdata_out,   // write data
  input  logic        rd_valid_in, // read answer strobe
  input  logic [31:0] rd_data_in   // read answer data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_out = 1'b0;
    write_out = 1'b0;
    index_out = 8'h00;
    wdata_out = 32'h00000000;
  end
  // one command, answer taken a cycle later, idle lines scrambled
  task automatic cmd(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [32:0] q);
    @(negedge clk_in);
    valid_out = 1'b1;
    write_out = w;
    index_out = idx;
    wdata_out = d;
    @(negedge clk_in);
    q = {rd_valid_in, rd_data_in};
    valid_out = 1'b0;
    write_out = ~w;
    index_out = ~idx;
    wdata_out = ~d;
  endtask
endmodule // cop_host_model

// >>> verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cv, cw, rv, vd, dp, fl, rdy;
  logic        v6 = 1'b0, tun = 1'b0, ppp = 1'b0, hdr = 1'b0, l4 = 1'b0, done = 1'b0;
  logic [7:0]  ci;
  logic [31:0] cd, rdat, w, tx_w, rx_w;
  logic [4:0]  en = 5'h00;
  logic [2:0]  pr = 3'h0;
  logic [2:0]  ev = 3'h0;
  wire  [14:0] st;
  logic [32:0] q;
  int          n_mismatch = 0;
  int          tests_run = 0;
  always #10 clk = ~clk;
  cop_host_model cop_host_model_inst (.clk_in(clk), .valid_out(cv), .write_out(cw),
    .index_out(ci), .wdata_out(cd), .rd_valid_in(rv), .rd_data_in(rdat));
  cop_policy_regs cop_policy_regs_inst (
    .CLOCK_IN(clk), .SYS_RST_IN(rst), .CMD_VALID_IN(cv), .CMD_WRITE_IN(cw),
    .CMD_INDEX_IN(ci), .CMD_WDATA_IN(cd), .CMD_READY_OUT(rdy), .RD_VALID_OUT(rv),
    .RD_DATA_OUT(rdat), .RX_CHECK_EN_IN(en), .RX_DONE_IN(done), .RX_IPV6_IN(v6),
    .RX_TUNNEL_IN(tun), .RX_PPPOE_IN(ppp), .RX_PROTO_IN(pr), .RX_IPHDR_ERR_IN(hdr),
    .RX_L4_ERR_IN(l4), .RX_VERDICT_OUT(vd), .RX_DROP_OUT(dp), .RX_FLAG_OUT(fl),
    .RX_TUNNEL_L4_CHECK_OUT(st[14]), .RX_PPPOE_PARSE_OUT(st[13]),
    .TX_IPV4_HDR_INSERT_OUT(st[0]), .TX_TCP_INSERT_OUT(st[1]), .TX_UDP_INSERT_OUT(st[2]),
    .TX_ICMP_INSERT_OUT(st[3]), .TX_IGMP_INSERT_OUT(st[4]), .TX_ICMPV6_INSERT_OUT(st[5]),
    .TX_V6_INSERT_OUT(st[10:6]), .TX_TUNNEL_L4_INSERT_OUT(st[11]),
    .TX_PPPOE_PARSE_OUT(st[12]));
  // verdict expected from the stored policy and current packet
  function automatic logic [2:0] exp_verdict();
    logic live, hf, lf, db, dr;
    live = pr <= 3'h4 && en[pr] && (!tun || rx_w[24]) && (!ppp || rx_w[25]);
    hf = hdr && !v6;
    lf = l4 && live;
    db = v6 ? rx_w[26 + pr] : rx_w[19 + pr];
    dr = hf && rx_w[16] || lf && db;
    return done ? {1'b1, dr, (hf || lf) && !dr} : 3'h0;
  endfunction
  // setting levels expected from the stored registers
  function automatic logic [14:0] exp_st();
    return {rx_w[24], rx_w[25], ~tx_w[17], tx_w[16], tx_w[12:8], tx_w[5:0]};
  endfunction
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // reads both registers, a write-only index and a random index
  task automatic check_regs();
    logic [7:0] ix;
    for (int i = 0; i < 4; i++) begin
      ix = i == 0 ? 8'h2d : i == 1 ? 8'h2b : i == 2 ? 8'h2e : 8'($urandom);
      cop_host_model_inst.cmd(1'b0, ix, 32'h00000000, q);
      chk("read", ix == 8'h2d ? {1'b1, tx_w} : ix == 8'h2b ? {1'b1, rx_w} : 33'h100000000, q);
    end
    chk("settings", 33'(exp_st()), 33'(st));
    chk("ready", 33'h000000001, 33'(rdy));
  endtask
  initial begin
    void'($urandom(32'hf49b));
    tx_w = 32'h00000000;
    rx_w = 32'h00000000;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check_regs();
    for (int i = 0; i < 24; i++) begin
      w = $urandom;
      cop_host_model_inst.cmd(1'b1, 8'h2e, w, q);
      tx_w = w & 32'h00031f3f;
      w = $urandom;
      cop_host_model_inst.cmd(1'b1, 8'h2c, w, q);
      rx_w = w & 32'h7fff0000;
      // writes to the read indexes must be ignored
      cop_host_model_inst.cmd(1'b1, 8'h2d, $urandom, q);
      cop_host_model_inst.cmd(1'b1, 8'h2b, $urandom, q);
      check_regs();
      // back-to-back packets under this policy
      for (int k = 0; k < 12; k++) begin
        @(negedge clk);
        chk("verdict", 33'(ev), 33'({vd, dp, fl}));
        {en, v6, tun, ppp, hdr, l4} = 10'($urandom);
        pr = 3'($urandom);
        done = k < 11;
        ev = exp_verdict();
      end
    end
    // second reset in mid-run clears everything
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    tx_w = 32'h00000000;
    rx_w = 32'h00000000;
    check_regs();
    conclude();
  end
  // watchdog well beyond the expected run length
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule // testbench
